// ### core/timed_pattern_unit.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "pattern_consts.svh"
// Overview of operation
// - Port B data holds the group 2/3 pattern, resets to zero.
// - Port data bits with enable set ignore CPU writes, still take transfers.
// - Selected match copies staged low-pair bits into port A data.
// - Groups 0/1 sharing trigger: one byte at first address, second reads ones.
// - Split triggers: group 1 upper nibble first address, group 0 low second.
// - Low-pair staged register clears to zero on reset.
// - Selected match copies staged high-pair bits into port B data.
// - Groups 2/3 sharing trigger: one byte at first address, second reads ones.
// - Split triggers: group 3 upper nibble first address, group 2 low second.
// - High-pair staged register clears to zero on reset.
// - Enabled low-pair bits transfer at their group's selected match.
// - Disabled low-pair bits never transfer; output unchanged.
// - Low-pair enable register clears to zero on reset.
// - Enabled high-pair bits transfer at their group's selected match.
// - Disabled high-pair bits never transfer; output unchanged.
// - High-pair enable register clears to zero on reset.
// - Trigger select resets to all ones, every group uses channel 3.
// - Select bits 7:6 pick group 3 channel 0..3.
// - Select bits 5:4 pick group 2 channel 0..3.
// - Select bits 3:2 pick group 1 channel 0..3.
// - Select bits 1:0 pick group 0 channel 0..3.
// - Pin drives whenever its direction bit is set; the transfer enable plays no part.
// - Normal mode triggers on compare match A of the selected channel.
module timed_pattern_unit (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [17:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [3:0]  cmp_a_i,
   input  wire logic [15:0] pin_i,
   output logic      [15:0] pattern_pin_o,
   output logic      [15:0] pattern_pin_oe_o
);
   import pattern_pkg::*;

   byte_t       port_a_pattern_data_r;
   byte_t       port_b_pattern_data_r;
   byte_t       port_a_dir_r;
   byte_t       port_b_dir_r;
   byte_t       staged_low_pair_data_r;
   byte_t       staged_high_pair_data_r;
   byte_t       low_pair_transfer_enable_r;
   byte_t       high_pair_transfer_enable_r;
   byte_t       group_trigger_select_r;
   bus_state_t  bus_state_r;
   logic [31:0] dat_r;

   // Bus decode
   wire logic [15:0] idx       = adr_i[17:2];
   wire logic        req       = cyc_i & stb_i & (bus_state_r == BUS_IDLE);
   wire logic        wr        = req & we_i & sel_i[0];
   wire byte_t       wd        = dat_i[7:0];
   wire logic        hit_pad   = idx == `IDX_PORT_A_DATA;
   wire logic        hit_pbd   = idx == `IDX_PORT_B_DATA;
   wire logic        hit_pad_d = idx == `IDX_PORT_A_DIR;
   wire logic        hit_pbd_d = idx == `IDX_PORT_B_DIR;
   wire logic        hit_sel   = idx == `IDX_TRIGGER_SEL;
   wire logic        hit_hen   = idx == `IDX_HIGH_ENABLE;
   wire logic        hit_len   = idx == `IDX_LOW_ENABLE;
   wire logic        hit_sh    = idx == `IDX_STAGED_HIGH;
   wire logic        hit_sl    = idx == `IDX_STAGED_LOW;
   wire logic        hit_sh2   = idx == `IDX_STAGED_G2_SPLIT;
   wire logic        hit_sl0   = idx == `IDX_STAGED_G0_SPLIT;

   // Pairs share a trigger when their select fields match
   wire logic low_same  = group_trigger_select_r[`SEL_G0_LSB +: 2]
                          == group_trigger_select_r[`SEL_G1_LSB +: 2];
   wire logic high_same = group_trigger_select_r[`SEL_G2_LSB +: 2]
                          == group_trigger_select_r[`SEL_G3_LSB +: 2];

   // Group trigger strobes, one per 4-bit group
   logic [3:0] fire;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : grp
         group_trigger u_trig (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .sel_i   (group_trigger_select_r[2*g +: 2]),
            .cmp_a_i (cmp_a_i),
            .fire_o  (fire[g])
         );
      end
   endgenerate

   // Staged register write masks per nibble
   wire logic wr_sl_hi = wr & hit_sl;
   wire logic wr_sl_lo = wr & (low_same ? hit_sl : hit_sl0);
   wire logic wr_sh_hi = wr & hit_sh;
   wire logic wr_sh_lo = wr & (high_same ? hit_sh : hit_sh2);

   wire byte_t staged_low_nxt  = {wr_sl_hi ? wd[7:4] : staged_low_pair_data_r[7:4],
                                  wr_sl_lo ? (low_same ? wd[3:0] : wd[3:0])
                                           : staged_low_pair_data_r[3:0]};
   wire byte_t staged_high_nxt = {wr_sh_hi ? wd[7:4] : staged_high_pair_data_r[7:4],
                                  wr_sh_lo ? wd[3:0] : staged_high_pair_data_r[3:0]};

   // Port data next values
   byte_t port_a_nxt;
   byte_t port_b_nxt;
   nibble_transfer u_a_lo (
      .cur_i    (port_a_pattern_data_r[3:0]),
      .staged_i (staged_low_pair_data_r[3:0]),
      .enable_i (low_pair_transfer_enable_r[3:0]),
      .fire_i   (fire[0]),
      .wr_i     (wr & hit_pad),
      .wdata_i  (wd[3:0]),
      .nxt_o    (port_a_nxt[3:0])
   );
   nibble_transfer u_a_hi (
      .cur_i    (port_a_pattern_data_r[7:4]),
      .staged_i (staged_low_pair_data_r[7:4]),
      .enable_i (low_pair_transfer_enable_r[7:4]),
      .fire_i   (fire[1]),
      .wr_i     (wr & hit_pad),
      .wdata_i  (wd[7:4]),
      .nxt_o    (port_a_nxt[7:4])
   );
   nibble_transfer u_b_lo (
      .cur_i    (port_b_pattern_data_r[3:0]),
      .staged_i (staged_high_pair_data_r[3:0]),
      .enable_i (high_pair_transfer_enable_r[3:0]),
      .fire_i   (fire[2]),
      .wr_i     (wr & hit_pbd),
      .wdata_i  (wd[3:0]),
      .nxt_o    (port_b_nxt[3:0])
   );
   nibble_transfer u_b_hi (
      .cur_i    (port_b_pattern_data_r[7:4]),
      .staged_i (staged_high_pair_data_r[7:4]),
      .enable_i (high_pair_transfer_enable_r[7:4]),
      .fire_i   (fire[3]),
      .wr_i     (wr & hit_pbd),
      .wdata_i  (wd[7:4]),
      .nxt_o    (port_b_nxt[7:4])
   );

   // Read mux
   wire byte_t rd_sl  = low_same  ? staged_low_pair_data_r
                                  : {staged_low_pair_data_r[7:4], 4'hf};
   wire byte_t rd_sl0 = low_same  ? `RESERVED_READ
                                  : {4'hf, staged_low_pair_data_r[3:0]};
   wire byte_t rd_sh  = high_same ? staged_high_pair_data_r
                                  : {staged_high_pair_data_r[7:4], 4'hf};
   wire byte_t rd_sh2 = high_same ? `RESERVED_READ
                                  : {4'hf, staged_high_pair_data_r[3:0]};
   wire byte_t pin_a  = (port_a_dir_r & port_a_pattern_data_r) | (~port_a_dir_r & pin_i[7:0]);
   wire byte_t pin_b  = (port_b_dir_r & port_b_pattern_data_r) | (~port_b_dir_r & pin_i[15:8]);
   wire logic  hit_any = hit_pad | hit_pbd | hit_pad_d | hit_pbd_d | hit_sel | hit_hen
                         | hit_len | hit_sh | hit_sl | hit_sh2 | hit_sl0;
   wire byte_t rd_byte = hit_pad ? pin_a :
                         hit_pbd ? pin_b :
                         hit_pad_d ? `RESERVED_READ :
                         hit_pbd_d ? `RESERVED_READ :
                         hit_sel ? group_trigger_select_r :
                         hit_hen ? high_pair_transfer_enable_r :
                         hit_len ? low_pair_transfer_enable_r :
                         hit_sh ? rd_sh :
                         hit_sl ? rd_sl :
                         hit_sh2 ? rd_sh2 : rd_sl0;
   wire logic [31:0] rd_word = hit_any ? {24'h00_0000, rd_byte} : `UNMAPPED_READ;

   // Pin drive
   assign pattern_pin_o    = {port_b_pattern_data_r, port_a_pattern_data_r};
   assign pattern_pin_oe_o = {port_b_dir_r, port_a_dir_r};
   assign ack_o            = bus_state_r == BUS_ACK;
   assign dat_o            = dat_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_r <= BUS_IDLE;
         dat_r       <= `UNMAPPED_READ;
      end else begin
         bus_state_r <= req ? BUS_ACK : BUS_IDLE;
         dat_r       <= req ? rd_word : dat_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_a_pattern_data_r <= `RST_DATA;
         port_b_pattern_data_r <= `RST_DATA;
      end else begin
         port_a_pattern_data_r <= port_a_nxt;
         port_b_pattern_data_r <= port_b_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         staged_low_pair_data_r  <= `RST_STAGED;
         staged_high_pair_data_r <= `RST_STAGED;
      end else begin
         staged_low_pair_data_r  <= staged_low_nxt;
         staged_high_pair_data_r <= staged_high_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_pair_transfer_enable_r  <= `RST_ENABLE;
         high_pair_transfer_enable_r <= `RST_ENABLE;
         group_trigger_select_r      <= `RST_TRIGGER_SEL;
         port_a_dir_r                <= `RST_DIR;
         port_b_dir_r                <= `RST_DIR;
      end else begin
         if (wr & hit_len) low_pair_transfer_enable_r <= wd;
         if (wr & hit_hen) high_pair_transfer_enable_r <= wd;
         if (wr & hit_sel) group_trigger_select_r <= wd;
         if (wr & hit_pad_d) port_a_dir_r <= wd;
         if (wr & hit_pbd_d) port_b_dir_r <= wd;
      end
   end

   // Checks
   logic past_valid_r;
   always_ff @(posedge clk_i) begin
      past_valid_r <= ~rst_i;
   end

   // Reset values
   reset_sel_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> group_trigger_select_r == 8'hff && staged_low_pair_data_r == 8'h00
                       && low_pair_transfer_enable_r == 8'h00 && port_b_pattern_data_r == 8'h00)
      else $error("Reset values wrong");
   reset_high_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> staged_high_pair_data_r == 8'h00 && high_pair_transfer_enable_r == 8'h00
                       && port_a_pattern_data_r == 8'h00)
      else $error("High pair reset values wrong");

   // Read-only port data bits
   b_ro_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_pbd && fire[3:2] == 2'b00) |=>
      ((port_b_pattern_data_r ^ $past(port_b_pattern_data_r))
       & $past(high_pair_transfer_enable_r)) == 8'h00)
      else $error("Enabled port B bit took a CPU write");
   a_ro_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_pad && fire[1:0] == 2'b00) |=>
      ((port_a_pattern_data_r ^ $past(port_a_pattern_data_r))
       & $past(low_pair_transfer_enable_r)) == 8'h00)
      else $error("Enabled port A bit took a CPU write");

   // Transfers
   a_transfer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (fire[0] && low_pair_transfer_enable_r[3:0] == 4'hf) |=>
      port_a_pattern_data_r[3:0] == $past(staged_low_pair_data_r[3:0]))
      else $error("Group 0 transfer missed");
   a_hi_transfer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (fire[1] && low_pair_transfer_enable_r[7:4] == 4'hf) |=>
      port_a_pattern_data_r[7:4] == $past(staged_low_pair_data_r[7:4]))
      else $error("Group 1 transfer missed");
   b_transfer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (fire[3] && high_pair_transfer_enable_r[7:4] == 4'hf) |=>
      port_b_pattern_data_r[7:4] == $past(staged_high_pair_data_r[7:4]))
      else $error("Group 3 transfer missed");
   b_lo_transfer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (fire[2] && high_pair_transfer_enable_r[3:0] == 4'hf) |=>
      port_b_pattern_data_r[3:0] == $past(staged_high_pair_data_r[3:0]))
      else $error("Group 2 transfer missed");
   a_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!(wr && hit_pad) && low_pair_transfer_enable_r == 8'h00) |=>
      $stable(port_a_pattern_data_r))
      else $error("Disabled port A bits changed");
   b_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!(wr && hit_pbd) && high_pair_transfer_enable_r == 8'h00) |=>
      $stable(port_b_pattern_data_r))
      else $error("Disabled port B bits changed");
   xfer_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_pad && fire[0]) |=>
      port_a_pattern_data_r[3:0] ==
      (($past(staged_low_pair_data_r[3:0]) & $past(low_pair_transfer_enable_r[3:0]))
       | ($past(wd[3:0]) & ~$past(low_pair_transfer_enable_r[3:0]))))
      else $error("CPU write beat a transfer");

   // Staged register address map
   low_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_sl0 && low_same) |=> dat_o == 32'h0000_00ff)
      else $error("Shared low pair second address not all ones");
   low_rsvd_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_sl0 && low_same) |=> $stable(staged_low_pair_data_r))
      else $error("Reserved low pair address took a write");
   low_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_sl && !low_same) |=> dat_o[3:0] == 4'hf)
      else $error("Split low pair unused nibble not ones");
   low_split_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_sl && !low_same) |=>
      staged_low_pair_data_r == {$past(wd[7:4]), $past(staged_low_pair_data_r[3:0])})
      else $error("Split low pair write hit the wrong nibble");
   high_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_sh && !high_same) |=> dat_o[3:0] == 4'hf)
      else $error("Split high pair unused nibble not ones");
   high_split_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_sh && !high_same) |=>
      staged_high_pair_data_r == {$past(wd[7:4]), $past(staged_high_pair_data_r[3:0])})
      else $error("Split high pair write hit the wrong nibble");
   high_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_sh2 && high_same) |=> dat_o == 32'h0000_00ff)
      else $error("Shared high pair second address not all ones");
   high_rsvd_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_sh2 && high_same) |=> $stable(staged_high_pair_data_r))
      else $error("Reserved high pair address took a write");

   // Control registers
   g1_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fire[1] == cmp_a_i[group_trigger_select_r[3:2]])
      else $error("Group 1 trigger wrong");
   sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_sel) |=> group_trigger_select_r == $past(wd))
      else $error("Trigger select write lost");
   low_en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_len) |=> low_pair_transfer_enable_r == $past(wd))
      else $error("Low enable write lost");
   high_en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_hen) |=> high_pair_transfer_enable_r == $past(wd))
      else $error("High enable write lost");
   oe_only_dir_a: assert property (@(posedge clk_i) disable iff (rst_i || !past_valid_r)
      (wr && hit_pad_d) |=> pattern_pin_oe_o[7:0] == $past(wd))
      else $error("Pin enable not from direction");

   // Bus handshake
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("Ack held too long");
   ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> ack_o)
      else $error("Request not acknowledged");
   unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && !hit_any) |=> dat_o == 32'h0000_0000)
      else $error("Unmapped read not zero");
   dat_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> dat_o[31:8] == 24'h00_0000)
      else $error("Read data upper bits not zero");

   write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr && hit_sl);
   fire_c: cover property (@(posedge clk_i) disable iff (rst_i)
      fire[2] && high_pair_transfer_enable_r != 8'h00);
   split_c: cover property (@(posedge clk_i) disable iff (rst_i) !low_same && wr && hit_sl0);
   collide_c: cover property (@(posedge clk_i) disable iff (rst_i) wr && hit_pad && fire[0]);
endmodule

// ### core/pattern_consts.svh
`ifndef PATTERN_CONSTS_SVH
`define PATTERN_CONSTS_SVH
// Printed offsets are not word aligned: they are register indices, byte address = 4 * index
`define IDX_PORT_A_DIR        16'hffd1
`define IDX_PORT_A_DATA       16'hffd3
`define IDX_PORT_B_DIR        16'hffd4
`define IDX_PORT_B_DATA       16'hffd6
`define IDX_TRIGGER_SEL       16'hffa1
`define IDX_HIGH_ENABLE       16'hffa2
`define IDX_LOW_ENABLE        16'hffa3
`define IDX_STAGED_HIGH       16'hffa4
`define IDX_STAGED_LOW        16'hffa5
`define IDX_STAGED_G2_SPLIT   16'hffa6
`define IDX_STAGED_G0_SPLIT   16'hffa7
`define RST_DATA              8'h00
`define RST_DIR               8'h00
`define RST_ENABLE            8'h00
`define RST_STAGED            8'h00
`define RST_TRIGGER_SEL       8'hff
`define RESERVED_READ         8'hff
`define UNMAPPED_READ         32'h0000_0000
`define SEL_G0_LSB            0
`define SEL_G1_LSB            2
`define SEL_G2_LSB            4
`define SEL_G3_LSB            6
`endif

// ### core/pattern_pkg.sv
package pattern_pkg;
   typedef logic [1:0] chan_sel_t;
   typedef logic [3:0] nibble_t;
   typedef logic [7:0] byte_t;
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;
endpackage

// ### core/group_trigger.sv
`timescale 1ns/1ps
// Picks one of four compare-match A strobes for a group
module group_trigger (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire pattern_pkg::chan_sel_t sel_i,
   input  wire logic [3:0]           cmp_a_i,
   output logic                      fire_o
);
   import pattern_pkg::*;

   assign fire_o = cmp_a_i[sel_i];

   sel_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fire_o == ((sel_i == 2'b00 && cmp_a_i[0]) || (sel_i == 2'b01 && cmp_a_i[1])
                 || (sel_i == 2'b10 && cmp_a_i[2]) || (sel_i == 2'b11 && cmp_a_i[3])))
      else $error("Group trigger does not follow selection");
endmodule

// ### core/nibble_transfer.sv
`timescale 1ns/1ps
// Next-value of one 4-bit port data nibble: hardware transfer wins over CPU write
module nibble_transfer (
   input  wire pattern_pkg::nibble_t cur_i,
   input  wire pattern_pkg::nibble_t staged_i,
   input  wire pattern_pkg::nibble_t enable_i,
   input  wire logic                fire_i,
   input  wire logic                wr_i,
   input  wire pattern_pkg::nibble_t wdata_i,
   output pattern_pkg::nibble_t     nxt_o
);
   import pattern_pkg::*;

   wire nibble_t xfer_mask = enable_i & {4{fire_i}};
   wire nibble_t cpu_mask  = ~enable_i & {4{wr_i}};
   wire nibble_t after_cpu = (cur_i & ~cpu_mask) | (wdata_i & cpu_mask);

   assign nxt_o = (after_cpu & ~xfer_mask) | (staged_i & xfer_mask);
endmodule

// ### sim/timer_match_model.sv
`timescale 1ns/1ps
// Timer side: one compare-match A strobe per request, after 0..3 idle cycles
module timer_match_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       go_i,
   input  wire logic [1:0] chan_i,
   input  wire logic [1:0] delay_i,
   output logic      [3:0] cmp_a_o,
   output logic            busy_o
);
   logic [1:0] cnt_r;
   logic [1:0] chan_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r   <= 2'h0;
         chan_r  <= 2'h0;
         busy_o  <= 1'b0;
         cmp_a_o <= 4'h0;
      end else begin
         cmp_a_o <= 4'h0;
         if (go_i) begin
            busy_o <= 1'b1;
            cnt_r  <= delay_i;
            chan_r <= chan_i;
         end else if (busy_o) begin
            if (cnt_r == 2'h0) begin
               cmp_a_o <= 4'h1 << chan_r;
               busy_o  <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 2'h1;
            end
         end
      end
   end
endmodule

// ### sim/timed_pattern_unit_tb_top.sv
`timescale 1ns/1ps
`include "pattern_consts.svh"
module timed_pattern_unit_tb_top;
   logic        clk_i, rst_i, cyc, stb, we, ack, go, busy;
   logic [17:0] adr;
   logic [3:0]  sel, cmp;
   logic [31:0] dat, rdat;
   logic [15:0] pin, po, poe, pat, en, wd;
   logic [7:0]  tp, da, db, a4, a5, a6, a7, sh, sl;
   logic [1:0]  ch, dly;
   logic [31:0] s;
   int          num_errors, samples_checked;
   timed_pattern_unit uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
      .cmp_a_i(cmp), .pin_i(pin), .pattern_pin_o(po), .pattern_pin_oe_o(poe));
   timer_match_model tmr (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .chan_i(ch),
      .delay_i(dly), .cmp_a_o(cmp), .busy_o(busy));
   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // Expected port data after a strobe on channel c
   function automatic logic [15:0] xfer(logic [15:0] p, logic [15:0] st, logic [15:0] e,
                                        logic [7:0] t, logic [1:0] c);
      for (int g = 0; g < 4; g++) begin
         if (t[2*g+:2] == c) begin
            p[4*g+:4] = (p[4*g+:4] & ~e[4*g+:4]) | (st[4*g+:4] & e[4*g+:4]);
         end
      end
      return p;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      sel <= 4'h1;
      adr <= {idx, 2'b00};
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk(16'h0, 16'h1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h0, q);
      chk({8'h0, q}, {8'h0, exp});
   endtask
   task automatic reset_check();
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(po, 16'h0);
      chk(poe, 16'h0);
      rchk(`IDX_TRIGGER_SEL, 8'hff);
      rchk(`IDX_HIGH_ENABLE, 8'h00);
      rchk(`IDX_LOW_ENABLE, 8'h00);
      rchk(`IDX_STAGED_LOW, 8'h00);
      rchk(`IDX_STAGED_HIGH, 8'h00);
      rchk(`IDX_STAGED_G0_SPLIT, 8'hff);
      wr(16'h0000, 8'h5a);
      rchk(16'h0000, 8'h00);
      $display("test reset done");
   endtask
   task automatic print_verdict();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      print_verdict();
   end
   initial begin
      {rst_i, cyc, stb, we, go} = 5'h10;
      {adr, sel, dat, pin, ch, dly} = '0;
      s = 32'h13;
      pat = 16'h0;
      reset_check();
      for (int i = 0; i < 40; i++) begin
         tp = 8'(rnd());
         if (i % 2 == 0) tp[7:6] = tp[5:4];
         if (i % 3 == 0) tp[3:2] = tp[1:0];
         {da, db} = 16'(rnd());
         en = 16'(rnd());
         wd = 16'(rnd());
         {a4, a5, a6, a7} = rnd();
         wr(`IDX_TRIGGER_SEL, tp);
         rchk(`IDX_TRIGGER_SEL, tp);
         wr(`IDX_PORT_A_DIR, da);
         wr(`IDX_PORT_B_DIR, db);
         wr(`IDX_LOW_ENABLE, en[7:0]);
         wr(`IDX_HIGH_ENABLE, en[15:8]);
         rchk(`IDX_LOW_ENABLE, en[7:0]);
         rchk(`IDX_HIGH_ENABLE, en[15:8]);
         wr(`IDX_PORT_A_DATA, wd[7:0]);
         wr(`IDX_PORT_B_DATA, wd[15:8]);
         pat = (pat & en) | (wd & ~en);
         chk(po, pat);
         wr(`IDX_STAGED_HIGH, a4);
         wr(`IDX_STAGED_LOW, a5);
         wr(`IDX_STAGED_G2_SPLIT, a6);
         wr(`IDX_STAGED_G0_SPLIT, a7);
         sh = (tp[7:6] == tp[5:4]) ? a4 : {a4[7:4], a6[3:0]};
         sl = (tp[3:2] == tp[1:0]) ? a5 : {a5[7:4], a7[3:0]};
         if (tp[7:6] == tp[5:4]) begin
            rchk(`IDX_STAGED_HIGH, sh);
            rchk(`IDX_STAGED_G2_SPLIT, 8'hff);
         end else begin
            rchk(`IDX_STAGED_HIGH, {sh[7:4], 4'hf});
            rchk(`IDX_STAGED_G2_SPLIT, {4'hf, sh[3:0]});
         end
         if (tp[3:2] == tp[1:0]) begin
            rchk(`IDX_STAGED_LOW, sl);
            rchk(`IDX_STAGED_G0_SPLIT, 8'hff);
         end else begin
            rchk(`IDX_STAGED_LOW, {sl[7:4], 4'hf});
            rchk(`IDX_STAGED_G0_SPLIT, {4'hf, sl[3:0]});
         end
         @(posedge clk_i);
         pin <= 16'(rnd());
         ch  <= 2'(rnd());
         dly <= 2'(rnd());
         go  <= 1'b1;
         @(posedge clk_i);
         go <= 1'b0;
         repeat (2) @(posedge clk_i);
         for (int n = 0; n < 10 && busy === 1'b1; n++) @(posedge clk_i);
         repeat (2) @(posedge clk_i);
         pat = xfer(pat, {sh, sl}, en, tp, ch);
         chk(po, pat);
         chk(poe, {db, da});
         rchk(`IDX_PORT_B_DATA, (pat[15:8] & db) | (pin[15:8] & ~db));
         $display("test pattern %0d done", i);
      end
      reset_check();
      print_verdict();
   end
endmodule
